/* File: verilog/srr_pkg.sv */
// Purpose: shared constants and types for the shift register ring counter
// Assumes: stage 0 is the first stage (A), stage 3 the last (D) of a unit
// Notes: one 8-bit chain is two 4-bit units, low unit first

package srr_pkg;

    // =========================================================
    // sizes
    localparam int UNIT_W = 4;
    localparam int CHAIN_W = 8;
    localparam int FIFO_DEPTH = 16;

    // =========================================================
    // reset values and preload patterns
    localparam logic [7:0] CHAIN_RESET = 8'h00;
    // pattern 1,0,0,0: only the first stage set
    localparam logic [3:0] RING_PRELOAD = 4'h1;
    // all-zero is a legal twisted-ring state, so recovery lands in the main loop
    localparam logic [3:0] TWIST_RECOVER = 4'h0;
    localparam int TWIST_PERIOD = 8;

    // =========================================================
    // modes of the low unit's feedback
    typedef enum logic [1:0] {
        SRR_PLAIN,
        SRR_RING,
        SRR_SELF,
        SRR_TWIST
    } srr_mode_e;

    typedef struct packed {
        logic [3:0] high;
        logic [3:0] low;
    } srr_par_s;

    // one shift step: serial bit into stage 0, others move toward the last stage
    function automatic logic [3:0] srr_shift4(input logic [3:0] v, input logic b);
        return {v[2:0], b};
    endfunction

    // first three stages all zero
    function automatic logic srr_lead_zero(input logic [3:0] v);
        return v[2:0] == 3'h0;
    endfunction

    // member of the eight-state twisted-ring sequence
    function automatic logic srr_twist_ok(input logic [3:0] v);
        case (v)
            4'h0, 4'h1, 4'h3, 4'h7, 4'hF, 4'hE, 4'hC, 4'h8: return 1'b1;
            default: return 1'b0;
        endcase
    endfunction

endpackage

/* File: verilog/srr_fifo.sv */
// Purpose: small first-word-fall-through fifo for chain snapshots
// Assumes: same falling clock edge as the register it serves
// Notes: head always sits in mem[0], so the output is a flip-flop

`timescale 1ns/10ps
`default_nettype none

module srr_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [CW-1:0] count;
    logic [CW-1:0] next_count;
    logic [CW-1:0] wr_idx;
    logic push;
    logic pop;

    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem[0];

    always_comb begin
        next_count = count;
        if (push && !pop) begin
            next_count = count + CW'(1);
        end else if (pop && !push) begin
            next_count = count - CW'(1);
        end
        wr_idx = pop ? count - CW'(1) : count;
    end

    // =========================================================
    // storage: shift toward the head on pop
    always_ff @(negedge clk) begin
        for (int i = 0; i < DEPTH; i++) begin
            if (push && i == int'(wr_idx)) begin
                mem[i] <= in_data;
            end else if (pop && i < DEPTH - 1) begin
                mem[i] <= mem[i + 1];
            end
        end
    end

    // =========================================================
    // occupancy and flags
    always_ff @(negedge clk) begin
        if (rst) begin
            count <= '0;
            in_ready <= 1'b0;
            out_valid <= 1'b0;
        end else begin
            count <= next_count;
            in_ready <= int'(next_count) < DEPTH;
            out_valid <= next_count != '0;
        end
    end

endmodule

`default_nettype wire

/* File: verilog/srr_top.sv */
// Purpose: two cascadable 4-bit shift units, ring and twisted-ring feedback on the low unit only
// Assumes: control inputs other than the asynchronous clear_n synchronous to clk; stages move on the falling edge
// Notes: each state change except a clear or reset is pushed into a snapshot fifo; a full fifo freezes the chain

`timescale 1ns/10ps
`default_nettype none

module srr_top
    import srr_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic clear_n,
    input wire srr_mode_e mode,
    input wire logic cascade,
    input wire logic shift_load,
    input wire logic ser_in,
    input wire logic ser_in_high,
    input wire srr_par_s par,
    output logic [7:0] stage,
    output logic snap_valid,
    input wire logic snap_ready,
    output logic [7:0] snap_data
);

    // =========================================================
    // next-state selection
    logic low_serial;
    logic low_shift;
    logic [3:0] low_load;
    logic high_serial;
    logic [3:0] next_low;
    logic [3:0] next_high;
    logic fifo_ready;
    logic fifo_push;

    always_comb begin
        low_serial = ser_in;
        low_shift = shift_load;
        low_load = par.low;
        case (mode)
            SRR_PLAIN: begin
                low_serial = ser_in;
            end
            SRR_RING: begin
                low_serial = stage[3];
            end
            SRR_SELF: begin
                // zero fill, not feedback: any start empties the lead stages within three shifts
                low_serial = 1'b0;
                // feedback pulls the unit into load when the lead stages are empty
                low_shift = shift_load && !srr_lead_zero(stage[3:0]);
                low_load = RING_PRELOAD;
            end
            SRR_TWIST: begin
                low_serial = ~stage[3];
                low_shift = shift_load && srr_twist_ok(stage[3:0]);
                low_load = TWIST_RECOVER;
            end
            default: begin
                low_serial = ser_in;
            end
        endcase
        next_low = low_shift ? srr_shift4(stage[3:0], low_serial) : low_load;
        high_serial = cascade ? stage[3] : ser_in_high;
        next_high = shift_load ? srr_shift4(stage[7:4], high_serial) : par.high;
    end

    // =========================================================
    // stages: falling edge, asynchronous clear wins over everything
    // a frozen chain loses no state: the fifo refuses, so nothing is dropped
    always_ff @(negedge clk or negedge clear_n) begin
        if (!clear_n) begin
            stage <= CHAIN_RESET;
        end else if (sys_rst) begin
            stage <= CHAIN_RESET;
        end else if (fifo_ready) begin
            stage <= {next_high, next_low};
        end
    end

    // =========================================================
    // snapshot buffer
    assign fifo_push = clear_n && !sys_rst;

    srr_fifo #(
        .WIDTH(CHAIN_W),
        .DEPTH(FIFO_DEPTH)
    ) u_snap (
        .clk(clk),
        .rst(sys_rst),
        .in_valid(fifo_push),
        .in_ready(fifo_ready),
        .in_data({next_high, next_low}),
        .out_valid(snap_valid),
        .out_ready(snap_ready),
        .out_data(snap_data)
    );

    // =========================================================
    // checks
    clear_forces_zero_a: assert property (
        @(negedge clk) disable iff (sys_rst)
        !clear_n |-> stage == CHAIN_RESET
    ) else $error("clear low but stages not zero");

    clear_holds_zero_a: assert property (
        @(negedge clk) disable iff (sys_rst)
        (!clear_n && !shift_load) ##1 !clear_n |-> stage == CHAIN_RESET
    ) else $error("load overrode clear");

    serial_capture_a: assert property (
        @(negedge clk) disable iff (sys_rst || !clear_n)
        (mode == SRR_PLAIN && shift_load && fifo_ready)
            |=> stage[0] == $past(ser_in)
    ) else $error("serial input not captured");

    shift_move_a: assert property (
        @(negedge clk) disable iff (sys_rst || !clear_n)
        (shift_load && fifo_ready)
            |=> stage[7:4] == {$past(stage[6:4]), $past(high_serial)}
    ) else $error("high unit did not shift");

    low_shift_move_a: assert property (
        @(negedge clk) disable iff (sys_rst || !clear_n)
        (low_shift && fifo_ready) |=> stage[3:1] == $past(stage[2:0])
    ) else $error("low unit did not shift");

    cascade_link_a: assert property (
        @(negedge clk) disable iff (sys_rst || !clear_n)
        (cascade && shift_load && fifo_ready) |=> stage[4] == $past(stage[3])
    ) else $error("cascade bit lost");

    chain_eight_a: assert property (
        @(negedge clk) disable iff (sys_rst || !clear_n)
        (mode == SRR_PLAIN && cascade && shift_load && fifo_ready)[*8]
            |=> stage[7] == $past(ser_in, 8)
    ) else $error("serial bit not at eighth stage after eight edges");

    par_load_a: assert property (
        @(negedge clk) disable iff (sys_rst || !clear_n)
        (!shift_load && fifo_ready && mode == SRR_PLAIN)
            |=> stage == $past(par)
    ) else $error("parallel load wrong");

    ring_rotate_a: assert property (
        @(negedge clk) disable iff (sys_rst || !clear_n)
        (mode == SRR_RING && shift_load && fifo_ready)
            |=> stage[3:0] == {$past(stage[2:0]), $past(stage[3])}
    ) else $error("ring did not rotate");

    self_preload_a: assert property (
        @(negedge clk) disable iff (sys_rst || !clear_n)
        (mode == SRR_SELF && srr_lead_zero(stage[3:0]) && fifo_ready)
            |=> stage[3:0] == RING_PRELOAD
    ) else $error("self-correcting ring missed preload");

    self_reach_a: assert property (
        @(negedge clk) disable iff (sys_rst || !clear_n)
        (mode == SRR_SELF && shift_load && fifo_ready)[*4]
            |-> $onehot(stage[3:0])
    ) else $error("ring not one-hot within three shifts");

    twist_step_a: assert property (
        @(negedge clk) disable iff (sys_rst || !clear_n)
        (mode == SRR_TWIST && shift_load && fifo_ready && srr_twist_ok(stage[3:0]))
            |=> stage[3:0] == {$past(stage[2:0]), ~$past(stage[3])}
    ) else $error("twisted ring step wrong");

    twist_period_a: assert property (
        @(negedge clk) disable iff (sys_rst || !clear_n)
        (mode == SRR_TWIST && shift_load && fifo_ready && srr_twist_ok(stage[3:0]))[*8]
            |=> stage[3:0] == $past(stage[3:0], TWIST_PERIOD)
    ) else $error("twisted ring period not eight");

    twist_fix_a: assert property (
        @(negedge clk) disable iff (sys_rst || !clear_n)
        (mode == SRR_TWIST && !srr_twist_ok(stage[3:0]) && fifo_ready)
            |=> stage[3:0] == TWIST_RECOVER
    ) else $error("unused twisted state not corrected");

    stall_hold_a: assert property (
        @(negedge clk) disable iff (sys_rst || !clear_n)
        !fifo_ready |=> $stable(stage)
    ) else $error("chain moved while fifo full");

endmodule

`default_nettype wire

/* File: tb/srr_sink.sv */
// Purpose: snapshot consumer standing in for the surrounding logic
// Assumes: fifo pops on the falling edge when valid and ready
// Notes: stall is commanded by the bench

`timescale 1ns/10ps
`default_nettype none

module srr_sink (
    input wire logic clk,
    input wire logic stall,
    input wire logic snap_valid,
    output logic snap_ready,
    input wire logic [7:0] snap_data
);
    logic [7:0] got [$];
    initial snap_ready = 1'b0;
    // ========================================
    // pop bookkeeping
    // stall sampled at the rising edge, so bench drives never race it
    always @(posedge clk) begin
        snap_ready <= #1 ~stall;
        #2;
        if (snap_valid && snap_ready) got.push_back(snap_data);
    end
endmodule

`default_nettype wire

/* File: tb/tb.sv */
// Purpose: self-checking bench for the shift register ring counter
// Assumes: design moves on the falling edge; bench drives after the rising
// Notes: expected states are rebuilt here step by step

`timescale 1ns/10ps
`default_nettype none

module tb;
    import srr_pkg::*;
    logic clk, sys_rst, clear_n, cascade, shift_load, ser_in, ser_in_high, stall, hit;
    srr_mode_e mode;
    srr_par_s par;
    logic [7:0] stage, snap_data, e;
    logic [3:0] v;
    logic snap_valid, snap_ready;
    int n_errors = 0;
    int tests_run = 0;
    logic [7:0] want [$];

    srr_top uut (.clk(clk), .sys_rst(sys_rst), .clear_n(clear_n), .mode(mode),
        .cascade(cascade), .shift_load(shift_load), .ser_in(ser_in),
        .ser_in_high(ser_in_high), .par(par), .stage(stage), .snap_valid(snap_valid),
        .snap_ready(snap_ready), .snap_data(snap_data));
    srr_sink prt (.clk(clk), .stall(stall), .snap_valid(snap_valid),
        .snap_ready(snap_ready), .snap_data(snap_data));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // ========================================
    // shared tasks
    task automatic tick();
        @(posedge clk);
        #1;
    endtask

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    task automatic load(input logic [7:0] d);
        mode = SRR_PLAIN;
        par = d;
        shift_load = 1'b0;
        tick();
        shift_load = 1'b1;
    endtask

    function automatic logic [3:0] tw(input logic [3:0] s);
        case (s)
            4'h0, 4'h1, 4'h3, 4'h7, 4'hF, 4'hE, 4'hC, 4'h8: return {s[2:0], ~s[3]};
            default: return 4'h0;
        endcase
    endfunction

    // ========================================
    // scenarios
    task automatic t_clear();
        load(8'h5A);
        check("load", stage, 8'h5A);
        par = 8'hC3;
        shift_load = 1'b0;
        clear_n = 1'b0;
        #1;
        check("clear", stage, 8'h00);
        repeat (2) tick();
        check("clear held", stage, 8'h00);
        clear_n = 1'b1;
        shift_load = 1'b1;
        $display("test clear done");
    endtask

    task automatic t_chain();
        e = 8'h00;
        mode = SRR_PLAIN;
        cascade = 1'b1;
        for (int i = 0; i < 11; i++) begin
            ser_in = (i == 0 || i == 2);
            tick();
            e = {e[6:0], ser_in};
            check("chain", stage, e);
        end
        $display("test chain done");
    endtask

    task automatic t_ring();
        load(8'h01);
        mode = SRR_RING;
        cascade = 1'b0;
        ser_in_high = 1'b1;
        e = 8'h01;
        repeat (8) begin
            tick();
            e = {e[6:4], ser_in_high, e[2:0], e[3]};
            check("ring", stage, e);
        end
        $display("test ring done");
    endtask

    task automatic t_self();
        load(8'h0F);
        mode = SRR_SELF;
        hit = 1'b0;
        // three shifts plus the preload edge
        repeat (4) if (!hit) begin
            tick();
            hit = (stage[3:0] === 4'h1);
        end
        check("self reach", {7'h00, hit}, 8'h01);
        v = 4'h1;
        repeat (4) begin
            tick();
            v = {v[2:0], v[3]};
            check("self ring", {4'h0, stage[3:0]}, {4'h0, v});
        end
        $display("test self done");
    endtask

    task automatic t_twist();
        load(8'h00);
        mode = SRR_TWIST;
        v = 4'h0;
        repeat (8) begin
            tick();
            v = tw(v);
            check("twist", {4'h0, stage[3:0]}, {4'h0, v});
        end
        load(8'h0B);
        mode = SRR_TWIST;
        tick();
        check("twist fix", {4'h0, stage[3:0]}, 8'h00);
        $display("test twist done");
    endtask

    task automatic t_fifo();
        mode = SRR_PLAIN;
        cascade = 1'b1;
        clear_n = 1'b0;
        repeat (20) tick();
        stall = 1'b1;
        repeat (2) tick();
        prt.got.delete();
        e = 8'h00;
        clear_n = 1'b1;
        // a full fifo of 16 words freezes the chain
        for (int i = 0; i < 20; i++) begin
            ser_in = i[0];
            tick();
            if (i < 16) begin
                e = {e[6:0], ser_in};
                want.push_back(e);
            end
            check("stall", stage, e);
        end
        stall = 1'b0;
        clear_n = 1'b0;
        repeat (20) tick();
        check("count", 8'(prt.got.size()), 8'h10);
        foreach (want[k]) check("snap", prt.got[k], want[k]);
        check("empty", {7'h00, snap_valid}, 8'h00);
        clear_n = 1'b1;
        $display("test fifo done");
    endtask

    // ========================================
    // main sequence and watchdog
    initial begin
        sys_rst = 1'b1;
        clear_n = 1'b1;
        mode = SRR_PLAIN;
        cascade = 1'b0;
        shift_load = 1'b1;
        ser_in = 1'b0;
        ser_in_high = 1'b0;
        stall = 1'b0;
        par = 8'h00;
        repeat (12) tick();
        check("reset", stage, 8'h00);
        sys_rst = 1'b0;
        repeat (2) tick();
        t_clear();
        t_chain();
        t_ring();
        t_self();
        t_twist();
        t_fifo();
        stop_test();
    end

    initial begin
        #20000;
        n_errors++;
        stop_test();
    end
endmodule

`default_nettype wire
